// ---- rtl/smbus_temp_pkg.sv ----
// constants and types shared by the temperature register port
package smbus_temp_pkg;
    // command codes of the byte registers
    localparam logic [7:0] CMD_CH1_TEMP = 8'h00;
    localparam logic [7:0] CMD_CH2_TEMP = 8'h01;
    localparam logic [7:0] CMD_CONFIG = 8'h02;
    // configuration field positions and reset value
    localparam int CFG_CH2_LOCAL_BIT = 1;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // reset value of the pointer and the readback of unmapped command codes
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // temperature byte codes
    localparam logic [7:0] CODE_DIODE_OPEN = 8'hef;
    localparam logic [7:0] CODE_DIODE_SHORT = 8'hff;
    localparam logic [7:0] TEMP_FLOOR = 8'h00;
    localparam logic [7:0] TEMP_CEIL = 8'hff;
    // slave address default, arbitrary value
    localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h4c;
    // bits in one byte, counted on the link
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_TURN = 3'b010,
        ST_CMD = 3'b011,
        ST_WDATA = 3'b100,
        ST_TX = 3'b101,
        ST_MACK = 3'b110
    } link_state_t;
endpackage

// ---- rtl/word_sync.sv ----
// toggle handshake that carries a word from one clock domain to another
`timescale 1ns/1ps
module word_sync #(
    parameter int WIDTH = 16
) (
    input wire logic src_clk_i,
    input wire logic dst_clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] src_data_i,
    output logic [WIDTH-1:0] dst_data_o,
    output logic dst_valid_o
);
    logic req_r;
    logic ack_r;
    logic [2:0] ack_s_r;
    logic [2:0] req_s_r;
    logic [WIDTH-1:0] hold_r;
    logic src_idle;
    logic req_new;

    // a new word is launched only once the last toggle came back and settled
    assign src_idle = (ack_s_r[1] == ack_s_r[2]) && (req_r == ack_s_r[2]);

    // source side: hold the word still while it is in flight
    always_ff @(posedge src_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_r <= 1'b0;
            hold_r <= '0;
        end else if (src_idle) begin
            hold_r <= src_data_i;
            req_r <= ~req_r;
        end
    end

    // acknowledge back into the source domain
    always_ff @(posedge src_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_s_r <= 3'b000;
        end else begin
            ack_s_r <= {ack_s_r[1:0], ack_r};
        end
    end

    // request into the destination domain over three stages
    always_ff @(posedge dst_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_s_r <= 3'b000;
        end else begin
            req_s_r <= {req_s_r[1:0], req_r};
        end
    end

    // a toggle counts once stages two and three agree on it
    assign req_new = (req_s_r[1] == req_s_r[2]) && (req_s_r[2] != ack_r);

    // destination side: take the word, return the toggle
    always_ff @(posedge dst_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dst_data_o <= '0;
            dst_valid_o <= 1'b0;
            ack_r <= 1'b0;
        end else begin
            dst_valid_o <= req_new;
            if (req_new) begin
                dst_data_o <= hold_r;
                ack_r <= req_s_r[2];
            end
        end
    end
endmodule

// ---- rtl/temp_format.sv ----
// converts one fixed-point temperature into its register byte
`timescale 1ns/1ps
module temp_format #(
    parameter int TEMP_W = 10,
    parameter int FRAC_W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic signed [TEMP_W-1:0] temp_i,
    input wire logic open_i,
    input wire logic short_i,
    output logic [7:0] code_o
);
    // half a degree at the input scale, used to round to nearest
    localparam logic signed [TEMP_W:0] HALF = (TEMP_W+1)'(1 << (FRAC_W - 1));

    logic signed [TEMP_W:0] sum;
    logic signed [TEMP_W:0] whole;

    // widened by one bit so the rounding add cannot wrap
    assign sum = {temp_i[TEMP_W-1], temp_i} + HALF;
    assign whole = sum >>> FRAC_W;

    // faults first, then clipping at both ends
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            code_o <= smbus_temp_pkg::TEMP_FLOOR;
        end else if (short_i) begin
            code_o <= smbus_temp_pkg::CODE_DIODE_SHORT;
        end else if (open_i) begin
            code_o <= smbus_temp_pkg::CODE_DIODE_OPEN;
        end else if (whole[TEMP_W]) begin
            code_o <= smbus_temp_pkg::TEMP_FLOOR;
        end else if (|whole[TEMP_W-1:8]) begin
            code_o <= smbus_temp_pkg::TEMP_CEIL; // saturate, no wrap
        end else begin
            code_o <= whole[7:0];
        end
    end

    property p_short_code;
        @(posedge clk_i) disable iff (!rst_n_i) short_i |=> code_o == 8'hff;
    endproperty
    a_short_code: assert property (p_short_code) else $error("short diode code wrong");

    property p_open_code;
        @(posedge clk_i) disable iff (!rst_n_i) (open_i && !short_i) |=> code_o == 8'hef;
    endproperty
    a_open_code: assert property (p_open_code) else $error("open diode code wrong");

    property p_clip_negative;
        @(posedge clk_i) disable iff (!rst_n_i)
            (!open_i && !short_i && temp_i < 0) |=> code_o == 8'h00;
    endproperty
    a_clip_negative: assert property (p_clip_negative) else $error("negative not clipped");

    property p_half_rounds_up;
        @(posedge clk_i) disable iff (!rst_n_i)
            (!open_i && !short_i && temp_i == TEMP_W'(1 << (FRAC_W - 1))) |=> code_o == 8'h01;
    endproperty
    a_half_rounds_up: assert property (p_half_rounds_up) else $error("half degree not rounded");

    property p_lsb_weight;
        @(posedge clk_i) disable iff (!rst_n_i)
            (!open_i && !short_i && temp_i == TEMP_W'(25 << FRAC_W)) |=> code_o == 8'h19;
    endproperty
    a_lsb_weight: assert property (p_lsb_weight) else $error("degree weighting wrong");
endmodule

// ---- rtl/smbus_temp_register_port.sv ----
// serial slave port with two temperature registers and a configuration byte
`timescale 1ns/1ps
module smbus_temp_register_port #(
    parameter logic [6:0] SLAVE_ADDR = smbus_temp_pkg::DEFAULT_SLAVE_ADDR,
    parameter int TEMP_W = 10,
    parameter int FRAC_W = 1
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic link_clk_i,
    input wire logic serial_clock_line_i,
    input wire logic serial_data_line_i,
    output logic serial_data_line_o,
    output logic serial_data_line_oe_n_o,
    input wire logic signed [TEMP_W-1:0] remote_diode_one_temp_i,
    input wire logic remote_diode_one_open_i,
    input wire logic remote_diode_one_short_i,
    input wire logic signed [TEMP_W-1:0] remote_diode_two_temp_i,
    input wire logic remote_diode_two_open_i,
    input wire logic remote_diode_two_short_i,
    input wire logic signed [TEMP_W-1:0] die_temp_i
);
    // ---- system clock side ----
    logic [2:0] ch2_local_s_r;
    logic ch2_local_r;
    logic signed [TEMP_W-1:0] ch2_temp;
    logic ch2_open;
    logic ch2_short;
    logic [7:0] ch1_code;
    logic [7:0] ch2_code;
    // ---- link clock side ----
    logic [2:0] scl_s_r;
    logic [2:0] sda_s_r;
    logic scl_f_r;
    logic sda_f_r;
    logic scl_prev_r;
    logic sda_prev_r;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    smbus_temp_pkg::link_state_t state_r;
    smbus_temp_pkg::link_state_t after_r;
    logic [3:0] bitcnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [7:0] ptr_r;
    logic [7:0] cfg_r;
    logic drive_low_r;
    logic [15:0] temps_link;
    logic byte_in;

    // configuration bit from the link domain, taken once stages two and three agree
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ch2_local_s_r <= 3'b000;
            ch2_local_r <= 1'b0;
        end else begin
            ch2_local_s_r <= {ch2_local_s_r[1:0], cfg_r[smbus_temp_pkg::CFG_CH2_LOCAL_BIT]};
            ch2_local_r <= (ch2_local_s_r[1] == ch2_local_s_r[2]) ? ch2_local_s_r[2] : ch2_local_r;
        end
    end

    // channel 2 source; the die sensor has no diode faults
    assign ch2_temp = ch2_local_r ? die_temp_i : remote_diode_two_temp_i;
    assign ch2_open = ch2_local_r ? 1'b0 : remote_diode_two_open_i;
    assign ch2_short = ch2_local_r ? 1'b0 : remote_diode_two_short_i;

    // channel 1 is wired to the first diode with no selection
    temp_format #(
        .TEMP_W(TEMP_W),
        .FRAC_W(FRAC_W)
    ) u_fmt_one (
        .clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .temp_i(remote_diode_one_temp_i),
        .open_i(remote_diode_one_open_i),
        .short_i(remote_diode_one_short_i),
        .code_o(ch1_code)
    );

    temp_format #(
        .TEMP_W(TEMP_W),
        .FRAC_W(FRAC_W)
    ) u_fmt_two (
        .clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .temp_i(ch2_temp),
        .open_i(ch2_open),
        .short_i(ch2_short),
        .code_o(ch2_code)
    );

    // both bytes travel together so a pair is never torn
    word_sync #(
        .WIDTH(16)
    ) u_temp_xfer (
        .src_clk_i(sys_clk_i),
        .dst_clk_i(link_clk_i),
        .rst_n_i(rst_n_i),
        .src_data_i({ch2_code, ch1_code}),
        .dst_data_o(temps_link),
        .dst_valid_o()
    );

    // register readback map, shared by address and master-ack loads
    function automatic logic [7:0] reg_read(input logic [7:0] ptr, input logic [15:0] temps,
                                            input logic [7:0] cfg);
        logic [7:0] val;
        val = smbus_temp_pkg::UNMAPPED_READ;
        if (ptr == smbus_temp_pkg::CMD_CH1_TEMP) begin
            val = temps[7:0];
        end else if (ptr == smbus_temp_pkg::CMD_CH2_TEMP) begin
            val = temps[15:8];
        end else if (ptr == smbus_temp_pkg::CMD_CONFIG) begin
            val = cfg;
        end
        return val;
    endfunction

    // pin synchronisers; a change counts once stages two and three agree
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_s_r <= 3'b111;
            sda_s_r <= 3'b111;
            scl_f_r <= 1'b1;
            sda_f_r <= 1'b1;
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            scl_s_r <= {scl_s_r[1:0], serial_clock_line_i};
            sda_s_r <= {sda_s_r[1:0], serial_data_line_i};
            scl_f_r <= (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_f_r;
            sda_f_r <= (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
            scl_prev_r <= scl_f_r;
            sda_prev_r <= sda_f_r;
        end
    end

    // bus events from the filtered lines
    assign scl_rise = scl_f_r & ~scl_prev_r;
    assign scl_fall = ~scl_f_r & scl_prev_r;
    assign start_seen = scl_f_r & scl_prev_r & sda_prev_r & ~sda_f_r;
    assign stop_seen = scl_f_r & scl_prev_r & ~sda_prev_r & sda_f_r;
    assign byte_in = scl_fall && (bitcnt_r == smbus_temp_pkg::BYTE_BITS);

    // transfer sequencer; a repeated start restarts from the address
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= smbus_temp_pkg::ST_IDLE;
            after_r <= smbus_temp_pkg::ST_IDLE;
            bitcnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            drive_low_r <= 1'b0;
        end else if (start_seen) begin
            state_r <= smbus_temp_pkg::ST_ADDR;
            bitcnt_r <= 4'h0;
            drive_low_r <= 1'b0;
        end else if (stop_seen) begin
            state_r <= smbus_temp_pkg::ST_IDLE;
            drive_low_r <= 1'b0;
        end else begin
            case (state_r)
                smbus_temp_pkg::ST_ADDR, smbus_temp_pkg::ST_CMD, smbus_temp_pkg::ST_WDATA: begin
                    if (scl_rise && bitcnt_r != smbus_temp_pkg::BYTE_BITS) begin
                        shift_r <= {shift_r[6:0], sda_f_r};
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end else if (byte_in) begin
                        bitcnt_r <= 4'h0;
                        state_r <= smbus_temp_pkg::ST_TURN;
                        drive_low_r <= 1'b1;
                        if (state_r != smbus_temp_pkg::ST_ADDR) begin
                            after_r <= smbus_temp_pkg::ST_WDATA;
                        end else if (shift_r[7:1] != SLAVE_ADDR) begin
                            state_r <= smbus_temp_pkg::ST_IDLE;
                            drive_low_r <= 1'b0;
                        end else if (shift_r[0]) begin
                            after_r <= smbus_temp_pkg::ST_TX;
                            tx_r <= reg_read(ptr_r, temps_link, cfg_r);
                        end else begin
                            after_r <= smbus_temp_pkg::ST_CMD;
                        end
                    end
                end
                smbus_temp_pkg::ST_TURN: begin
                    // end of an acknowledge clock hands the line over
                    if (scl_fall) begin
                        state_r <= after_r;
                        bitcnt_r <= 4'h0;
                        drive_low_r <= 1'b0;
                        if (after_r == smbus_temp_pkg::ST_TX) begin
                            drive_low_r <= ~tx_r[7];
                            tx_r <= {tx_r[6:0], 1'b0};
                            bitcnt_r <= 4'h1;
                        end
                    end
                end
                smbus_temp_pkg::ST_TX: begin
                    if (byte_in) begin
                        drive_low_r <= 1'b0;
                        state_r <= smbus_temp_pkg::ST_MACK;
                    end else if (scl_fall) begin
                        drive_low_r <= ~tx_r[7];
                        tx_r <= {tx_r[6:0], 1'b0};
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end
                end
                smbus_temp_pkg::ST_MACK: begin
                    // host ack repeats the same register, a nack ends it
                    if (scl_rise) begin
                        if (sda_f_r) begin
                            state_r <= smbus_temp_pkg::ST_IDLE;
                        end else begin
                            state_r <= smbus_temp_pkg::ST_TURN;
                            after_r <= smbus_temp_pkg::ST_TX;
                            tx_r <= reg_read(ptr_r, temps_link, cfg_r);
                        end
                    end
                end
                default: begin
                    drive_low_r <= 1'b0;
                end
            endcase
        end
    end

    // command pointer survives stops so a receive byte can reuse it
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ptr_r <= smbus_temp_pkg::PTR_RESET;
        end else if (!start_seen && !stop_seen && state_r == smbus_temp_pkg::ST_CMD && byte_in) begin
            ptr_r <= shift_r;
        end
    end

    // configuration write; writes to read-only or unmapped codes are dropped
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_r <= smbus_temp_pkg::CFG_RESET;
        end else if (!start_seen && !stop_seen && state_r == smbus_temp_pkg::ST_WDATA && byte_in
                     && ptr_r == smbus_temp_pkg::CMD_CONFIG) begin
            cfg_r <= shift_r;
        end
    end

    // open drain: only ever pull low
    assign serial_data_line_o = 1'b0;
    assign serial_data_line_oe_n_o = ~drive_low_r;

    property p_foreign_addr;
        @(posedge link_clk_i) disable iff (!rst_n_i)
            (state_r == smbus_temp_pkg::ST_ADDR && byte_in && !start_seen && !stop_seen
             && shift_r[7:1] != SLAVE_ADDR)
            |=> (state_r == smbus_temp_pkg::ST_IDLE && !drive_low_r) [*2];
    endproperty
    a_foreign_addr: assert property (p_foreign_addr) else $error("foreign address disturbed bus");

    property p_own_addr;
        @(posedge link_clk_i) disable iff (!rst_n_i)
            (state_r == smbus_temp_pkg::ST_ADDR && byte_in && !start_seen && !stop_seen
             && shift_r[7:1] == SLAVE_ADDR) |=> serial_data_line_oe_n_o == 1'b0;
    endproperty
    a_own_addr: assert property (p_own_addr) else $error("own address not acknowledged");

    property p_cmd_ack;
        @(posedge link_clk_i) disable iff (!rst_n_i)
            (state_r == smbus_temp_pkg::ST_CMD && byte_in && !start_seen && !stop_seen)
            |=> drive_low_r && ptr_r == $past(shift_r) && after_r == smbus_temp_pkg::ST_WDATA;
    endproperty
    a_cmd_ack: assert property (p_cmd_ack) else $error("command byte not taken");

    property p_read_pointer;
        @(posedge link_clk_i) disable iff (!rst_n_i)
            (state_r == smbus_temp_pkg::ST_ADDR && byte_in && !start_seen && !stop_seen
             && shift_r == {SLAVE_ADDR, 1'b1})
            |=> tx_r == reg_read($past(ptr_r), $past(temps_link), $past(cfg_r));
    endproperty
    a_read_pointer: assert property (p_read_pointer) else $error("read not from pointer");

    property p_ch1_map;
        @(posedge link_clk_i) disable iff (!rst_n_i)
            (state_r == smbus_temp_pkg::ST_ADDR && byte_in && !start_seen && !stop_seen
             && shift_r == {SLAVE_ADDR, 1'b1} && ptr_r == 8'h00) |=> tx_r == $past(temps_link[7:0]);
    endproperty
    a_ch1_map: assert property (p_ch1_map) else $error("command zero not channel 1");

    property p_msb_first;
        @(posedge link_clk_i) disable iff (!rst_n_i)
            (state_r == smbus_temp_pkg::ST_TURN && scl_fall && !start_seen && !stop_seen
             && after_r == smbus_temp_pkg::ST_TX) |=> drive_low_r == ~$past(tx_r[7]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first data bit not msb");

    property p_cfg_write;
        @(posedge link_clk_i) disable iff (!rst_n_i)
            (state_r == smbus_temp_pkg::ST_WDATA && byte_in && !start_seen && !stop_seen
             && ptr_r == 8'h02) |=> cfg_r == $past(shift_r) ##1 $stable(cfg_r);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("configuration write lost");

    property p_ch2_source;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
            ch2_local_r |-> ch2_temp == die_temp_i && !ch2_open && !ch2_short;
    endproperty
    a_ch2_source: assert property (p_ch2_source) else $error("channel 2 source wrong");

    c_read_byte: cover property (@(posedge link_clk_i) disable iff (!rst_n_i)
        state_r == smbus_temp_pkg::ST_TX ##[1:1000] state_r == smbus_temp_pkg::ST_MACK);
    c_write_cfg: cover property (@(posedge link_clk_i) disable iff (!rst_n_i)
        state_r == smbus_temp_pkg::ST_WDATA && byte_in && ptr_r == smbus_temp_pkg::CMD_CONFIG);
    c_foreign: cover property (@(posedge link_clk_i) disable iff (!rst_n_i)
        state_r == smbus_temp_pkg::ST_ADDR && byte_in && shift_r[7:1] != SLAVE_ADDR);
endmodule

// ---- verification/smbus_host_model.sv ----
// host controller model that clocks the serial link
`timescale 1ns/1ps
module smbus_host_model #(
    parameter int HALF_NS = 1000
) (
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // both lines released at power-up, pull-ups hold them high
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // start or repeated start; sole master, so nobody else moves the pointer
    task automatic start_cond();
        sda_low_o = 1'b0;
        #(HALF_NS) scl_o = 1'b1;
        #(HALF_NS) sda_low_o = 1'b1;
        #(HALF_NS) scl_o = 1'b0;
    endtask
    // stop: data rises while clock high, then a short bus free time
    task automatic stop_cond();
        #(HALF_NS*2/5) sda_low_o = 1'b1;
        #(HALF_NS*3/5) scl_o = 1'b1;
        #(HALF_NS) sda_low_o = 1'b0;
        #(HALF_NS*2);
    endtask
    // nine clocks msb first; data held well past the synced clock fall
    task automatic clock_bits(input logic [8:0] out, output logic [8:0] seen);
        for (int i = 8; i >= 0; i--) begin
            #(HALF_NS*2/5) sda_low_o = ~out[i];
            #(HALF_NS*3/5) scl_o = 1'b1;
            #(HALF_NS/4) seen[i] = sda_i;
            #(HALF_NS/4) scl_o = 1'b0;
        end
    endtask
endmodule

// ---- verification/test_smbus_temp_register_port.sv ----
// self-checking bench for the temperature register port
`timescale 1ns/1ps
module test_smbus_temp_register_port;
    localparam logic [6:0] ADDR = 7'h4c;
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl, host_low, sda_o, sda_oe_n, sda;
    logic signed [9:0] t_one = 10'sh032, t_two = 10'sh0c8, t_die = 10'sh03c;
    logic one_open = 1'b0, one_short = 1'b0, two_open = 1'b0, two_short = 1'b0;
    logic signed [9:0] temps [4] = '{10'sh032, 10'sh001, -10'sh006, 10'sh1e2};
    logic [7:0] codes [4] = '{8'h19, 8'h01, 8'h00, 8'hf1};
    int n_mismatch = 0;
    int compares = 0;
    // open-drain data wire with pull-up
    assign sda = !(host_low || (!sda_oe_n && !sda_o));
    always #4 sys_clk = ~sys_clk;
    // link clock, phase offset from the system clock
    initial begin
        #7;
        forever #24 link_clk = ~link_clk;
    end
    smbus_host_model u_host (.sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
    smbus_temp_register_port #(.SLAVE_ADDR(ADDR)) u_dut (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .link_clk_i(link_clk),
        .serial_clock_line_i(scl), .serial_data_line_i(sda),
        .serial_data_line_o(sda_o), .serial_data_line_oe_n_o(sda_oe_n),
        .remote_diode_one_temp_i(t_one), .remote_diode_one_open_i(one_open),
        .remote_diode_one_short_i(one_short), .remote_diode_two_temp_i(t_two),
        .remote_diode_two_open_i(two_open), .remote_diode_two_short_i(two_short),
        .die_temp_i(t_die));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one byte out, device acknowledge expected low
    task automatic put(input logic [7:0] b);
        logic [8:0] s;
        u_host.clock_bits({b, 1'b1}, s);
        chk("ack", {7'h00, s[0]}, 8'h00);
    endtask
    // one byte in, host answers not-acknowledge
    task automatic take(output logic [7:0] b);
        logic [8:0] s;
        u_host.clock_bits(9'h1ff, s);
        b = s[8:1];
    endtask
    task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
        logic [7:0] b;
        u_host.start_cond();
        put({ADDR, 1'b0});
        put(cmd);
        u_host.start_cond();
        put({ADDR, 1'b1});
        take(b);
        u_host.stop_cond();
        chk("read byte", b, exp);
    endtask
    task automatic recv(input logic [7:0] exp);
        logic [7:0] b;
        u_host.start_cond();
        put({ADDR, 1'b1});
        take(b);
        u_host.stop_cond();
        chk("receive byte", b, exp);
    endtask
    // write byte, or send byte when no data follows
    task automatic wr(input logic [7:0] cmd, input logic [7:0] d, input bit with_data);
        u_host.start_cond();
        put({ADDR, 1'b0});
        put(cmd);
        if (with_data) put(d);
        u_host.stop_cond();
    endtask
    // lets temperature inputs cross into the link domain
    task automatic settle();
        repeat (300) @(negedge sys_clk);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // hang guard, about one and a half times the expected run
    initial begin
        #1_500_000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        logic [8:0] s;
        logic [7:0] b;
        // long enough for both clock domains to see reset
        repeat (24) @(negedge sys_clk);
        rst_n = 1'b1;
        settle();
        recv(8'h19);
        for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk);
            t_one = temps[i];
            settle();
            recv(codes[i]);
        end
        @(negedge sys_clk);
        one_open = 1'b1;
        settle();
        recv(8'hef);
        @(negedge sys_clk);
        one_short = 1'b1;
        settle();
        recv(8'hff);
        @(negedge sys_clk);
        one_open = 1'b0;
        one_short = 1'b0;
        t_one = 10'sh032;
        $display("test channel one formats done");
        rd(smbus_temp_pkg::CMD_CH2_TEMP, 8'h64);
        wr(smbus_temp_pkg::CMD_CONFIG, 8'h02, 1'b1);
        rd(smbus_temp_pkg::CMD_CONFIG, 8'h02);
        settle();
        rd(smbus_temp_pkg::CMD_CH2_TEMP, 8'h1e);
        rd(smbus_temp_pkg::CMD_CH1_TEMP, 8'h19);
        wr(smbus_temp_pkg::CMD_CONFIG, 8'h00, 1'b1);
        settle();
        $display("test channel two source done");
        wr(smbus_temp_pkg::CMD_CH2_TEMP, 8'h00, 1'b0);
        recv(8'h64);
        rd(8'h05, 8'h00);
        wr(smbus_temp_pkg::CMD_CH1_TEMP, 8'h55, 1'b1);
        recv(8'h19);
        // host acknowledges the first byte, so the same register comes again
        u_host.start_cond();
        put({ADDR, 1'b1});
        u_host.clock_bits(9'h1fe, s);
        take(b);
        u_host.stop_cond();
        chk("acked read", s[8:1], 8'h19);
        chk("repeat read", b, 8'h19);
        $display("test pointer and read-only done");
        u_host.start_cond();
        u_host.clock_bits({ADDR ^ 7'h01, 2'b11}, s);
        u_host.stop_cond();
        chk("foreign ack", {7'h00, s[0]}, 8'h01);
        recv(8'h19);
        $display("test foreign address done");
        wrap_up();
    end
endmodule
